// >>> core/dbp_pkg.sv
// Package for the dual-branch PLL clock select block: register map, field positions,
// oscillator codes, frequency tables and timing counts.
// Assumes a 200 MHz control clock and a 32-bit APB register bus.
package dbp_pkg;
  localparam int         CLK_MHZ          = 200;
  localparam logic [7:0] ADDR_OSC_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PLL_CFG     = 8'h04;
  localparam logic [7:0] ADDR_STATUS      = 8'h08;

  // Oscillator control fields.
  localparam int NEW_OSC_LSB  = 0;
  localparam int CUR_OSC_LSB  = 4;
  localparam int SW_REQ_BIT   = 8;
  localparam int RC_8MHZ_BIT  = 9;
  // PLL configuration fields.
  localparam int MULT_LSB     = 0;
  localparam int DIV_LSB      = 4;
  localparam int PRI_FREQ_LSB = 8;
  // Status fields.
  localparam int STS_FREQ_LSB = 0;
  localparam int STS_BUSY_BIT = 8;
  localparam int STS_LOCK_BIT = 9;
  localparam int STS_ERR_BIT  = 10;
  localparam int STS_USB_BIT  = 11;

  // Oscillator select codes.
  localparam logic [2:0] OSC_FRC     = 3'h0;
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRI     = 3'h2;
  localparam logic [2:0] OSC_PRI_PLL = 3'h3;

  // Multiplier codes: 4'h0..4'h7 run the 96 MHz branch, these three the fixed branch.
  localparam logic [3:0] MULT_FIXED_X4 = 4'h8;
  localparam logic [3:0] MULT_FIXED_X6 = 4'h9;
  localparam logic [3:0] MULT_FIXED_X8 = 4'ha;

  localparam logic [7:0] PLL96_MHZ       = 8'h60;
  localparam logic [7:0] USB_MHZ         = 8'h30;
  localparam logic [7:0] SYSCLK_MAX_MHZ  = 8'h20;
  localparam logic [7:0] FIN_MIN_MHZ     = 8'h04;
  localparam logic [7:0] PRI_MAX_MHZ     = 8'h30;
  localparam logic [7:0] FRC_LO_MHZ      = 8'h04;
  localparam logic [7:0] FRC_HI_MHZ      = 8'h08;
  localparam logic [7:0] RESET_SYSCLK_MHZ = 8'h04;

  // Required input frequency per 96 MHz branch multiplier code 0..7.
  localparam logic [7:0] PLL96_FIN_MHZ [8] = '{8'h04, 8'h08, 8'h0c, 8'h10,
                                               8'h14, 8'h18, 8'h20, 8'h30};

  // Timing: output gate-off time and PLL settle time.
  localparam int GATE_TIME_NS = 20;
  localparam int LOCK_TIME_US = 2;
  localparam int GATE_CYC     = (GATE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;
  localparam int CNT_W        = 10;

  // System clock routing.
  localparam logic [1:0] BR_DIRECT = 2'h0;
  localparam logic [1:0] BR_FIXED  = 2'h1;
  localparam logic [1:0] BR_PLL96  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_GATE_OFF = 2'b01,
    ST_LOCK     = 2'b10
  } dbp_state_e;
endpackage : dbp_pkg

// >>> core/dbp_clock_select.sv
// Clock select controller for a PLL with a fixed-multiplier branch and a 96 MHz branch.
// Assumes an APB master on clk; oscillator ready pins are asynchronous and synchronised here.
`timescale 1ns/10ps
`default_nettype none
module dbp_clock_select #(
  parameter bit HAS_USB = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        primary_osc_ready,
  input  wire logic        fast_rc_oscillator_ready,
  output logic      [1:0]  sysclk_branch_sel,
  output logic             sysclk_gate_en,
  output logic      [7:0]  sysclk_freq_mhz,
  output logic      [7:0]  fixed_ref_freq_mhz,
  output logic             pll96_ref_valid,
  output logic             usb_clk_valid,
  output logic             rc_self_tune_req
);

  // Software registers.
  logic [2:0] new_osc_select_r;
  logic [2:0] current_osc_select_r;
  logic       switch_req_r;
  logic       rc_8mhz_r;
  logic [3:0] pll_multiplier_code_r;
  logic [1:0] sysclk_divider_select_r;
  logic [5:0] pri_freq_r;
  logic       cfg_err_r;

  // Switch engine state.
  dbp_pkg::dbp_state_e state_r;
  dbp_pkg::dbp_state_e state_nxt;
  logic [dbp_pkg::CNT_W-1:0] cnt_r;
  logic [1:0] act_branch_r;
  logic [2:0] act_osc_r;
  logic [7:0] act_freq_r;
  logic [7:0] act_fixed_r;
  logic       locked_r;

  // Two-flop synchronisers for the oscillator ready pins.
  logic [1:0] pri_sync_r;
  logic [1:0] frc_sync_r;

  // APB decode.
  wire        apb_acc   = psel & penable;
  wire        wr_osc    = apb_acc & pwrite & (paddr == dbp_pkg::ADDR_OSC_CTRL);
  wire        wr_cfg    = apb_acc & pwrite & (paddr == dbp_pkg::ADDR_PLL_CFG);
  wire        wr_sts    = apb_acc & pwrite & (paddr == dbp_pkg::ADDR_STATUS);
  wire        hit_osc   = (paddr == dbp_pkg::ADDR_OSC_CTRL);
  wire        hit_cfg   = (paddr == dbp_pkg::ADDR_PLL_CFG);
  wire        hit_sts   = (paddr == dbp_pkg::ADDR_STATUS);
  wire        hit_any   = hit_osc | hit_cfg | hit_sts;

  // Requested configuration, evaluated before a switch is allowed to start.
  wire        req_use_frc = (new_osc_select_r == dbp_pkg::OSC_FRC) |
                            (new_osc_select_r == dbp_pkg::OSC_FRC_PLL);
  wire        req_use_pll = (new_osc_select_r == dbp_pkg::OSC_FRC_PLL) |
                            (new_osc_select_r == dbp_pkg::OSC_PRI_PLL);
  wire        req_known   = (new_osc_select_r == dbp_pkg::OSC_FRC) |
                            (new_osc_select_r == dbp_pkg::OSC_PRI) | req_use_pll;
  wire [7:0]  req_fin     = req_use_frc ?
                            (rc_8mhz_r ? dbp_pkg::FRC_HI_MHZ : dbp_pkg::FRC_LO_MHZ) :
                            {2'h0, pri_freq_r};
  wire        req_is96    = ~pll_multiplier_code_r[3];
  wire        req_x4      = (pll_multiplier_code_r == dbp_pkg::MULT_FIXED_X4);
  wire        req_x6      = (pll_multiplier_code_r == dbp_pkg::MULT_FIXED_X6);
  wire        req_x8      = (pll_multiplier_code_r == dbp_pkg::MULT_FIXED_X8);
  wire [9:0]  fin_w       = {2'h0, req_fin};
  wire [9:0]  req_fout    = req_x4 ? {fin_w[7:0], 2'h0} :
                            req_x6 ? ({fin_w[7:0], 2'h0} + {fin_w[8:0], 1'h0}) :
                            {fin_w[6:0], 3'h0};
  wire [7:0]  req_fin96   = dbp_pkg::PLL96_FIN_MHZ[pll_multiplier_code_r[2:0]];
  wire [7:0]  req_div96   = dbp_pkg::SYSCLK_MAX_MHZ >> sysclk_divider_select_r;
  wire        pri_ok      = (req_fin[1:0] == 2'h0) & (req_fin >= dbp_pkg::FIN_MIN_MHZ) &
                            (req_fin <= dbp_pkg::PRI_MAX_MHZ);
  wire        ok96        = req_is96 & (req_fin == req_fin96);
  wire        okfix       = (req_x4 | req_x6 | req_x8) &
                            (req_fout <= {2'h0, dbp_pkg::SYSCLK_MAX_MHZ});
  wire        req_valid   = req_known & (~req_use_pll |
                            ((req_use_frc | pri_ok) & (ok96 | okfix)));
  wire [1:0]  req_branch  = ~req_use_pll ? dbp_pkg::BR_DIRECT :
                            (req_is96 ? dbp_pkg::BR_PLL96 : dbp_pkg::BR_FIXED);
  // A direct primary source above 32 MHz is also refused so sysclk stays in range.
  wire        req_in_range = req_use_pll | (req_fin <= dbp_pkg::SYSCLK_MAX_MHZ);
  wire [7:0]  req_sysclk  = ~req_use_pll ? req_fin :
                            (req_is96 ? req_div96 : req_fout[7:0]);

  wire src_ready = (act_osc_r == dbp_pkg::OSC_FRC) | (act_osc_r == dbp_pkg::OSC_FRC_PLL) ?
                   frc_sync_r[1] : pri_sync_r[1];
  wire cnt_zero  = (cnt_r == '0);
  wire start_sw  = (state_r == dbp_pkg::ST_IDLE) & switch_req_r & req_valid & req_in_range;
  wire reject_sw = (state_r == dbp_pkg::ST_IDLE) & switch_req_r & ~(req_valid & req_in_range);
  wire done_sw   = (state_r == dbp_pkg::ST_LOCK) & cnt_zero & src_ready;
  wire gate_hit  = (state_r == dbp_pkg::ST_GATE_OFF) & cnt_zero;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dbp_pkg::ST_IDLE: begin
        if (start_sw) begin
          state_nxt = dbp_pkg::ST_GATE_OFF;
        end
      end
      dbp_pkg::ST_GATE_OFF: begin
        if (cnt_zero) begin
          state_nxt = dbp_pkg::ST_LOCK;
        end
      end
      dbp_pkg::ST_LOCK: begin
        if (done_sw) begin
          state_nxt = dbp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = dbp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pri_sync_r <= 2'h0;
      frc_sync_r <= 2'h0;
    end else begin
      pri_sync_r <= {pri_sync_r[0], primary_osc_ready};
      frc_sync_r <= {frc_sync_r[0], fast_rc_oscillator_ready};
    end
  end

  // Register file. Hardware events win over a software clear in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      new_osc_select_r        <= dbp_pkg::OSC_FRC;
      rc_8mhz_r               <= 1'b0;
      switch_req_r            <= 1'b0;
      pll_multiplier_code_r   <= 4'h0;
      sysclk_divider_select_r <= 2'h0;
      pri_freq_r              <= 6'h00;
      cfg_err_r               <= 1'b0;
    end else begin
      if (wr_osc) begin
        new_osc_select_r <= pwdata[dbp_pkg::NEW_OSC_LSB +: 3];
        rc_8mhz_r        <= pwdata[dbp_pkg::RC_8MHZ_BIT];
      end
      if (wr_cfg) begin
        pll_multiplier_code_r   <= pwdata[dbp_pkg::MULT_LSB +: 4];
        sysclk_divider_select_r <= pwdata[dbp_pkg::DIV_LSB +: 2];
        pri_freq_r              <= pwdata[dbp_pkg::PRI_FREQ_LSB +: 6];
      end
      switch_req_r <= (wr_osc & pwdata[dbp_pkg::SW_REQ_BIT]) |
                      (switch_req_r & ~(done_sw | reject_sw));
      cfg_err_r    <= reject_sw | (cfg_err_r & ~(wr_sts & pwdata[dbp_pkg::STS_ERR_BIT]));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= dbp_pkg::ST_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (start_sw) begin
        cnt_r <= dbp_pkg::CNT_W'(dbp_pkg::GATE_CYC - 1);
      end else if (gate_hit) begin
        cnt_r <= dbp_pkg::CNT_W'(dbp_pkg::LOCK_CYC - 1);
      end else if (!cnt_zero) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // The new configuration is captured at the start of a switch, so later writes
  // cannot disturb a switch already in flight.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_branch_r <= dbp_pkg::BR_DIRECT;
      act_osc_r    <= dbp_pkg::OSC_FRC;
      act_freq_r   <= dbp_pkg::RESET_SYSCLK_MHZ;
      act_fixed_r  <= 8'h00;
    end else if (start_sw) begin
      act_branch_r <= req_branch;
      act_osc_r    <= new_osc_select_r;
      act_freq_r   <= req_sysclk;
      act_fixed_r  <= (req_use_pll & ~req_is96) ? req_fout[7:0] : 8'h00;
    end
  end

  // The gate drops before the selector moves and rises only after the source has
  // settled, so the consumer never sees a runt pulse from either branch.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sysclk_gate_en       <= 1'b1;
      sysclk_branch_sel    <= dbp_pkg::BR_DIRECT;
      current_osc_select_r <= dbp_pkg::OSC_FRC;
      sysclk_freq_mhz      <= dbp_pkg::RESET_SYSCLK_MHZ;
      fixed_ref_freq_mhz   <= 8'h00;
      locked_r             <= 1'b0;
      pll96_ref_valid      <= 1'b0;
      usb_clk_valid        <= 1'b0;
      rc_self_tune_req     <= 1'b0;
    end else begin
      if (start_sw) begin
        sysclk_gate_en  <= 1'b0;
        locked_r        <= 1'b0;
        pll96_ref_valid <= 1'b0;
        usb_clk_valid   <= 1'b0;
      end
      if (gate_hit) begin
        sysclk_branch_sel <= act_branch_r;
      end
      if (done_sw) begin
        sysclk_gate_en       <= 1'b1;
        current_osc_select_r <= act_osc_r;
        sysclk_freq_mhz      <= act_freq_r;
        fixed_ref_freq_mhz   <= act_fixed_r;
        locked_r             <= (act_branch_r != dbp_pkg::BR_DIRECT);
        pll96_ref_valid      <= (act_branch_r == dbp_pkg::BR_PLL96);
        usb_clk_valid        <= HAS_USB & (act_branch_r == dbp_pkg::BR_PLL96);
        rc_self_tune_req     <= (act_branch_r == dbp_pkg::BR_PLL96) &
                                (act_osc_r == dbp_pkg::OSC_FRC_PLL);
      end
    end
  end

  // Read data; unmapped addresses answer with an error and zero data.
  wire [31:0] rd_osc = {22'h0, rc_8mhz_r, switch_req_r, 1'b0, current_osc_select_r,
                        1'b0, new_osc_select_r};
  wire [31:0] rd_cfg = {18'h0, pri_freq_r, 2'h0, sysclk_divider_select_r,
                        pll_multiplier_code_r};
  wire [31:0] rd_sts = {20'h0, usb_clk_valid, cfg_err_r, locked_r,
                        (state_r != dbp_pkg::ST_IDLE), sysclk_freq_mhz};

  assign prdata  = hit_osc ? rd_osc : hit_cfg ? rd_cfg : hit_sts ? rd_sts : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

endmodule : dbp_clock_select
`default_nettype wire

// >>> verification/dbp_osc_model.sv
// Behavioural model of the primary and fast RC oscillators on the ready pins.
// Assumes the bench enables each source; ready rises after a start-up delay.
`timescale 1ns/10ps
`default_nettype none
module dbp_osc_model #(
  parameter int PRI_DLY = 600,
  parameter int RC_DLY  = 3
) (
  input  wire logic clk,
  input  wire logic pri_en,
  input  wire logic rc_en,
  output logic      primary_osc_ready,
  output logic      fast_rc_oscillator_ready
);
  int pri_cnt = 0;
  int rc_cnt  = 0;
  // A slow primary start forces a switch to wait on the pin, not on its own timer.
  always @(posedge clk) begin
    pri_cnt <= pri_en ? pri_cnt + 1 : 0;
    rc_cnt  <= rc_en ? rc_cnt + 1 : 0;
  end
  assign primary_osc_ready        = pri_cnt >= PRI_DLY;
  assign fast_rc_oscillator_ready = rc_cnt >= RC_DLY;
endmodule : dbp_osc_model
`default_nettype wire

// >>> verification/dbp_clock_select_checker.sv
// Port assertions for the clock select block.
// Assumes it is bound into every dbp_clock_select instance.
`timescale 1ns/10ps
`default_nettype none
module dbp_clock_select_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  sysclk_branch_sel,
  input wire logic        sysclk_gate_en,
  input wire logic [7:0]  sysclk_freq_mhz,
  input wire logic [7:0]  fixed_ref_freq_mhz,
  input wire logic        pll96_ref_valid,
  input wire logic        usb_clk_valid,
  input wire logic        rc_self_tune_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic on96 = sysclk_branch_sel == dbp_pkg::BR_PLL96;
  wire logic onfx = sysclk_branch_sel == dbp_pkg::BR_FIXED;
  logic [9:0] low_cnt;
  // Counts cycles with the gate shut, so a reopen is checked against the whole
  // gate-off plus settle time without a long repetition.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt <= 10'h000;
    end else if (sysclk_gate_en) begin
      low_cnt <= 10'h000;
    end else if (low_cnt != 10'h3ff) begin
      low_cnt <= low_cnt + 10'h001;
    end
  end
  sequence s_gate_low; !sysclk_gate_en [*8]; endsequence
  sequence s_sel_still; $stable(sysclk_branch_sel) [*4]; endsequence
  a_freq_max: assert property (sysclk_freq_mhz <= 8'h20)
    else $error("system clock above limit");
  a_sel_gated: assert property ($changed(sysclk_branch_sel) |-> !sysclk_gate_en)
    else $error("branch changed while clock passed");
  a_gate_hold: assert property ($fell(sysclk_gate_en) |=> s_gate_low)
    else $error("gate reopened too soon");
  a_sel_settle: assert property ($fell(sysclk_gate_en) |-> s_sel_still)
    else $error("branch moved before gate settled");
  a_usb_branch: assert property (sysclk_gate_en |-> usb_clk_valid == on96)
    else $error("usb valid does not follow branch");
  a_ref96_branch: assert property (sysclk_gate_en |-> pll96_ref_valid == on96)
    else $error("reference valid does not follow branch");
  a_pll96_freq: assert property (sysclk_gate_en && on96 |->
    sysclk_freq_mhz inside {8'h04, 8'h08, 8'h10, 8'h20}) else $error("bad divided frequency");
  a_fixed_ref: assert property (sysclk_gate_en |->
    fixed_ref_freq_mhz == (onfx ? sysclk_freq_mhz : 8'h00)) else $error("fixed ref wrong");
  a_tune_branch: assert property (rc_self_tune_req && sysclk_gate_en |-> on96)
    else $error("self tune outside the 96 MHz branch");
  a_slverr_map: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08})
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_ready_zero: assert property (psel && penable |-> pready)
    else $error("access phase stretched");
  a_lock_wait: assert property ($rose(sysclk_gate_en) |->
    low_cnt >= 10'(dbp_pkg::GATE_CYC + dbp_pkg::LOCK_CYC))
    else $error("gate reopened before settle time");
endmodule : dbp_clock_select_checker
bind dbp_clock_select dbp_clock_select_checker u_chk (.clk, .reset, .psel, .penable, .pready,
  .paddr, .prdata, .pslverr, .sysclk_branch_sel, .sysclk_gate_en, .sysclk_freq_mhz,
  .fixed_ref_freq_mhz, .pll96_ref_valid, .usb_clk_valid, .rc_self_tune_req);
`default_nettype wire

// >>> verification/dbp_clock_select_tb.sv
// Self-checking bench for the clock select block: APB driver, result queue, monitor.
// Assumes the oscillator model on the ready pins and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module dbp_clock_select_tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} dbp_exp_s;
  dbp_exp_s    q[$];
  dbp_exp_s    x;
  int          err_count = 0;
  int          checks = 0;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        pri_en = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, primary_osc_ready, fast_rc_oscillator_ready;
  logic        sysclk_gate_en, pll96_ref_valid, usb_clk_valid, rc_self_tune_req;
  logic [1:0]  sysclk_branch_sel;
  logic [7:0]  sysclk_freq_mhz, fixed_ref_freq_mhz;
  logic [1:0]  dv;
  logic [5:0]  fin [8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h30};
  logic [2:0]  bad_osc [6] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h2, 3'h5};
  logic [13:0] bad_cfg [6] = '{14'h080a, 14'h2c07, 14'h3407, 14'h040b, 14'h2800, 14'h0400};
  dbp_clock_select dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .primary_osc_ready, .fast_rc_oscillator_ready, .sysclk_branch_sel,
    .sysclk_gate_en, .sysclk_freq_mhz, .fixed_ref_freq_mhz, .pll96_ref_valid,
    .usb_clk_valid, .rc_self_tune_req);
  dbp_osc_model osc (.clk, .pri_en, .rc_en(1'b1), .primary_osc_ready,
    .fast_rc_oscillator_ready);
  always #2.5 clk = ~clk;
  task automatic check(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    checks++;
    if ((g & m) !== (e & m)) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : check
  // Reads note the expected word; writes note only the expected error flag.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    dbp_exp_s n;
    n.d = d;
    n.m = m;
    n.e = !(a inside {8'h00, 8'h04, 8'h08});
    q.push_back(n);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, e, m);
  endtask : rd
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (sysclk_gate_en !== 1'b1 && n < 3000);
    if (sysclk_gate_en !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t switch did not finish", $time);
    end
  endtask : settle
  task automatic sw(input logic [2:0] o, input logic [13:0] c, input logic r8);
    wr(8'h04, {18'h0, c});
    wr(8'h00, {22'h0, r8, 1'b1, 5'h0, o});
    settle();
  endtask : sw
  task automatic port(input logic [1:0] s, input logic [7:0] f, input logic [7:0] r,
                      input logic [2:0] v);
    check({10'h0, sysclk_gate_en, sysclk_branch_sel, usb_clk_valid, pll96_ref_valid,
           rc_self_tune_req, sysclk_freq_mhz, fixed_ref_freq_mhz},
          {10'h0, 1'b1, s, v, f, r}, 32'h3fffff);
  endtask : port
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      x = q.pop_front();
      check({31'h0, pslverr}, {31'h0, x.e}, 32'h1);
      check(prdata, x.d, pwrite ? 32'h0 : x.m);
    end
  end
  initial begin
    #150000;
    err_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h405d));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    pri_en <= 1'b1;
    @(negedge clk);
    port(dbp_pkg::BR_DIRECT, 8'h04, 8'h00, 3'h0);
    rd(8'h00, 32'h0, 32'h377);
    rd(8'h04, 32'h0, 32'h3f3f);
    rd(8'h0c, 32'h0, 32'hffffffff);
    wr(8'h08, 32'hff);
    rd(8'h08, 32'h4, 32'hfff);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      dv = 2'($urandom_range(3));
      sw(3'h3, {fin[i], 2'b0, dv, 4'(i)}, 1'b0);
      port(dbp_pkg::BR_PLL96, 8'h20 >> dv, 8'h00, 3'b110);
      rd(8'h00, 32'h33, 32'h377);
    end
    for (int r = 0; r < 2; r++) begin
      sw(3'h1, {8'h0, dv, 4'(r)}, 1'(r));
      port(dbp_pkg::BR_PLL96, 8'h20 >> dv, 8'h00, 3'b111);
    end
    for (int k = 0; k < 3; k++) begin
      sw(3'h3, {6'h04, 4'h0, 4'(8 + k)}, 1'b0);
      port(dbp_pkg::BR_FIXED, 8'(16 + 8 * k), 8'(16 + 8 * k), 3'h0);
    end
    $display("test branches done");
    for (int j = 0; j < 6; j++) begin
      sw(bad_osc[j], bad_cfg[j], 1'b0);
      port(dbp_pkg::BR_FIXED, 8'h20, 8'h20, 3'h0);
      rd(8'h00, {28'h3, 1'b0, bad_osc[j]}, 32'h377);
      rd(8'h08, 32'h620, 32'hfff);
      wr(8'h08, 32'h400);
      rd(8'h08, 32'h220, 32'hfff);
    end
    $display("test rejects done");
    sw(3'h2, 14'h1800, 1'b0);
    port(dbp_pkg::BR_DIRECT, 8'h18, 8'h00, 3'h0);
    sw(3'h0, 14'h0, 1'b1);
    port(dbp_pkg::BR_DIRECT, 8'h08, 8'h00, 3'h0);
    wr(8'h04, 32'h0408);
    wr(8'h00, 32'h103);
    wr(8'h04, 32'h3007);
    settle();
    port(dbp_pkg::BR_FIXED, 8'h10, 8'h10, 3'h0);
    // A valid switch is left in flight so the reset below lands mid-switch.
    wr(8'h00, 32'h103);
    rd(8'h08, 32'h110, 32'hfff);
    repeat (20) @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    port(dbp_pkg::BR_DIRECT, 8'h04, 8'h00, 3'h0);
    rd(8'h00, 32'h0, 32'h377);
    rd(8'h08, 32'h4, 32'hfff);
    $display("test switching done");
    close_out();
  end
endmodule : dbp_clock_select_tb
`default_nettype wire
